/* rtl/agl_lock_det.sv */
// synthesizer lock detector: window test, counter and lock hysteresis
`timescale 1ns/100ps
module agl_lock_det (
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    // configuration
    input  wire agl_pkg::agl_lock_cfg_s cfg_i,
    // comparison results
    input  wire logic                   cmp_valid_i,
    input  wire logic [2:0]             cmp_offset_i,
    // status
    output agl_pkg::agl_lock_st_s       st_o
);
    import agl_pkg::*;

    logic [9:0] count;
    logic [9:0] next_count;
    logic       hit;
    logic       locked;
    logic       instant;
    logic       gain_p;
    logic       loss_p;

    // a comparison counts as a hit when its offset falls inside the window
    assign hit = cmp_offset_i < (cfg_i.window_wide ? WIN_WIDE : WIN_NARROW);

    // counter update; saturation keeps a long lock from wrapping into a loss
    always_comb begin
        next_count = count;
        if (cmp_valid_i) begin
            if (hit) begin
                next_count = (count == CNT_MAX) ? count : count + 10'h001;
            end else if (!cfg_i.up_down) begin
                next_count = 10'h000;
            end else begin
                next_count = (count == 10'h000) ? count : count - 10'h001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= 10'h000;
        end else begin
            count <= next_count;
        end
    end

    // lock state with separate enter and leave thresholds
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            locked <= 1'b0;
            gain_p <= 1'b0;
            loss_p <= 1'b0;
        end else begin
            gain_p <= 1'b0;
            loss_p <= 1'b0;
            if (!locked && next_count >= LOCK_THR[cfg_i.accuracy]) begin
                locked <= 1'b1;
                gain_p <= 1'b1;
            end else if (locked && next_count <= LOSS_THR[cfg_i.accuracy]) begin
                locked <= 1'b0;
                loss_p <= 1'b1;
            end
        end
    end

    // instant lock follows the latest comparison
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            instant <= 1'b0;
        end else if (cmp_valid_i) begin
            instant <= hit;
        end
    end

    assign st_o.continuous_lock_flag = locked;
    assign st_o.instant_lock_flag    = instant;
    assign st_o.lock_gain            = gain_p;
    assign st_o.lock_loss            = loss_p;

endmodule

/* rtl/agl_pkg.sv */
// constants, register map and types for the gain control and lock detect block
//
// Contract
// - gain steps down when strength exceeds carrier level + 8 + increase code + 3 + decrease code.
// - gain steps up when strength is below carrier level + 8 + increase code, unless at ceiling.
// - the 5-bit initial gain (reset 24) is loaded into the amplifier when receive turns on.
// - automatic control never raises gain above the initial gain field, which is the ceiling.
// - the 5-bit carrier level (reset 24) is the reference for carrier sense and gain thresholds.
// - a 4-bit selector drives the status pin: 0 low, 1 high, 2-6 status, 7-15 internal taps.
// - selector 2-6 give continuous instant_lock_flag lock, carrier sense, cal done, sequencing error, all active low.
// - carrier sense is asserted (pin low) while measured strength is above the carrier level.
// - the lock window is 2 prescaler cycles wide when the window bit is 0, 4 when it is 1.
// - the lock counter restarts on a miss when the mode bit is 0 and counts up/down when it is 1.
// - lock is declared at 127/255/511/1023 and lost at 111/239/495/1007 for accuracy 0-3.
// - with automatic gain off, the gain is held at the initial gain field.
// - with the two-sample filter on, two equal consecutive decisions are needed before a step.
package agl_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_GAIN_CEIL   = 6'h13;
    localparam logic [5:0] IDX_GAIN_INC    = 6'h14;
    localparam logic [5:0] IDX_LOCK_PIN    = 6'h15;
    localparam logic [5:0] IDX_AGC_CTRL    = 6'h18;
    localparam logic [5:0] IDX_IRQ_STATUS  = 6'h19;
    localparam logic [5:0] IDX_IRQ_MASK    = 6'h1A;
    localparam logic [5:0] IDX_LIVE_STATUS = 6'h1B;

    // reset values
    localparam logic [7:0] RST_GAIN_CEIL = 8'h38;   // decrease code 1, initial gain 24
    localparam logic [7:0] RST_GAIN_INC  = 8'h38;   // increase code 1, carrier level 24
    localparam logic [7:0] RST_LOCK_PIN  = 8'h00;
    localparam logic [1:0] RST_AGC_CTRL  = 2'h2;    // gain control on, two-sample filter on

    // field positions
    localparam int CODE_MSB  = 7;
    localparam int CODE_LSB  = 5;
    localparam int LEVEL_MSB = 4;
    localparam int SEL_MSB   = 7;
    localparam int SEL_LSB   = 4;
    localparam int WIN_BIT   = 3;
    localparam int MODE_BIT  = 2;
    localparam int CTRL_OFF  = 0;
    localparam int CTRL_FILT = 1;

    // interrupt event bits
    localparam int EV_LOCK_GAIN = 0;
    localparam int EV_LOCK_LOSS = 1;
    localparam int EV_CS_RISE   = 2;
    localparam int EV_NUM       = 3;

    // threshold offsets in strength steps of 1.5 dB
    localparam logic [6:0] THR_BASE     = 7'h08;
    localparam logic [6:0] THR_DOWN_MIN = 7'h03;

    // lock detector windows in prescaler cycles and counter thresholds
    localparam logic [2:0] WIN_NARROW = 3'h2;
    localparam logic [2:0] WIN_WIDE   = 3'h4;
    localparam logic [9:0] CNT_MAX    = 10'h3FF;
    localparam logic [9:0] LOCK_THR [4] = '{10'h07F, 10'h0FF, 10'h1FF, 10'h3FF};
    localparam logic [9:0] LOSS_THR [4] = '{10'h06F, 10'h0EF, 10'h1EF, 10'h3EF};

    // status pin selector codes
    localparam logic [3:0] SEL_LOW     = 4'h0;
    localparam logic [3:0] SEL_HIGH    = 4'h1;
    localparam logic [3:0] SEL_CONT    = 4'h2;
    localparam logic [3:0] SEL_INST    = 4'h3;
    localparam logic [3:0] SEL_CS      = 4'h4;
    localparam logic [3:0] SEL_CAL     = 4'h5;
    localparam logic [3:0] SEL_SEQ     = 4'h6;
    localparam logic [3:0] SEL_TAP0    = 4'h7;
    localparam int         TAP_NUM     = 9;

    // gain step decision
    typedef enum logic [1:0] {
        DIR_HOLD = 2'b00,
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } agl_dir_e;

    // lock detector configuration
    typedef struct packed {
        logic       window_wide;
        logic       up_down;
        logic [1:0] accuracy;
    } agl_lock_cfg_s;

    // lock detector results
    typedef struct packed {
        logic continuous_lock_flag;
        logic instant_lock_flag;
        logic lock_gain;
        logic lock_loss;
    } agl_lock_st_s;

endpackage

/* rtl/agl_top.sv */
// gain control, carrier sense, lock detect and status pin with an AHB-Lite register slave
`timescale 1ns/100ps
module agl_top (
    // clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        resetn_i,
    // AHB-Lite slave
    input  wire logic                        hsel_i,
    input  wire logic [7:0]                  haddr_i,
    input  wire logic [1:0]                  htrans_i,
    input  wire logic                        hwrite_i,
    input  wire logic [2:0]                  hsize_i,
    input  wire logic [31:0]                 hwdata_i,
    input  wire logic                        hready_i,
    output logic      [31:0]                 hrdata_o,
    output logic                             hreadyout_o,
    output logic                             hresp_o,
    // receive chain
    input  wire logic                        rx_on_i,
    input  wire logic                        strength_valid_i,
    input  wire logic [6:0]                  strength_i,
    output logic      [4:0]                  vga_gain_o,
    // synthesizer comparisons
    input  wire logic                        cmp_valid_i,
    input  wire logic [2:0]                  cmp_offset_i,
    // other status sources and internal clock taps
    input  wire logic                        cal_done_i,
    input  wire logic                        sequencing_error_flag_i,
    input  wire logic [agl_pkg::TAP_NUM-1:0] taps_i,
    // outputs
    output logic                             status_pin_o,
    output logic                             irq_o
);
    import agl_pkg::*;

    // registers
    logic [7:0]        gain_ceil_reg;
    logic [7:0]        gain_inc_reg;
    logic [7:0]        lock_pin_reg;
    logic [1:0]        agc_ctrl;
    logic [EV_NUM-1:0] irq_status;
    logic [EV_NUM-1:0] irq_mask;

    // bus pipeline
    logic              wr_pend;
    logic [5:0]        wr_idx;
    logic [31:0]       next_rdata;

    // datapath
    logic [4:0]        ceiling;
    logic [4:0]        cs_level;
    logic [6:0]        up_thr;
    logic [6:0]        down_thr;
    logic              carrier_sense;
    logic              cs_prev;
    logic              rx_prev;
    agl_dir_e          want;
    agl_dir_e          pend;
    agl_dir_e          apply;
    logic [4:0]        gain;
    agl_lock_cfg_s     lock_cfg;
    agl_lock_st_s      lock_st;
    logic [EV_NUM-1:0] events;
    logic [EV_NUM-1:0] clr_bits;
    logic [3:0]        pin_sel;
    logic              next_pin;

    // bus slave

    // zero wait states and always OKAY keep the master simple
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // address phase capture; byte address bits [1:0] are ignored
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend <= 1'b0;
            wr_idx  <= 6'h00;
        end else if (hready_i) begin
            wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
            wr_idx  <= haddr_i[7:2];
        end
    end

    // read mux; unmapped indices read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr_i[7:2])
            IDX_GAIN_CEIL:   next_rdata[7:0] = gain_ceil_reg;
            IDX_GAIN_INC:    next_rdata[7:0] = gain_inc_reg;
            IDX_LOCK_PIN:    next_rdata[7:0] = lock_pin_reg;
            IDX_AGC_CTRL:    next_rdata[1:0] = agc_ctrl;
            IDX_IRQ_STATUS:  next_rdata[EV_NUM-1:0] = irq_status;
            IDX_IRQ_MASK:    next_rdata[EV_NUM-1:0] = irq_mask;
            IDX_LIVE_STATUS: next_rdata[9:0] = {lock_st.instant_lock_flag,
                                                lock_st.continuous_lock_flag,
                                                carrier_sense, 2'h0, gain};
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    // read data registered at the address phase, stands in the data phase
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            hrdata_o <= next_rdata;
        end
    end

    // configuration writes land in the data phase
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gain_ceil_reg <= RST_GAIN_CEIL;
            gain_inc_reg  <= RST_GAIN_INC;
            lock_pin_reg  <= RST_LOCK_PIN;
            agc_ctrl      <= RST_AGC_CTRL;
            irq_mask      <= '0;
        end else if (wr_pend) begin
            unique case (wr_idx)
                IDX_GAIN_CEIL: gain_ceil_reg <= hwdata_i[7:0];
                IDX_GAIN_INC:  gain_inc_reg  <= hwdata_i[7:0];
                IDX_LOCK_PIN:  lock_pin_reg  <= hwdata_i[7:0];
                IDX_AGC_CTRL:  agc_ctrl      <= hwdata_i[1:0];
                IDX_IRQ_MASK:  irq_mask      <= hwdata_i[EV_NUM-1:0];
                default:       agc_ctrl      <= agc_ctrl;
            endcase
        end
    end

    // interrupts

    assign clr_bits = (wr_pend && wr_idx == IDX_IRQ_STATUS) ? hwdata_i[EV_NUM-1:0] : '0;
    assign events   = {carrier_sense && !cs_prev, lock_st.lock_loss, lock_st.lock_gain};

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~clr_bits) | events;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // gain control

    assign ceiling  = gain_ceil_reg[LEVEL_MSB:0];
    assign cs_level = gain_inc_reg[LEVEL_MSB:0];
    assign up_thr   = {2'h0, cs_level} + THR_BASE
                    + {4'h0, gain_inc_reg[CODE_MSB:CODE_LSB]};
    assign down_thr = up_thr + THR_DOWN_MIN
                    + {4'h0, gain_ceil_reg[CODE_MSB:CODE_LSB]};

    // carrier sense compares against the same reference as the gain thresholds
    assign carrier_sense = strength_i > {2'h0, cs_level};

    // raw decision for the current strength sample
    always_comb begin
        want = DIR_HOLD;
        if (strength_i > down_thr && gain != 5'h00) begin
            want = DIR_DOWN;
        end else if (strength_i < up_thr && gain < ceiling) begin
            want = DIR_UP;
        end
    end

    // the filter needs the same decision on two samples in a row
    always_comb begin
        apply = DIR_HOLD;
        if (strength_valid_i) begin
            if (!agc_ctrl[CTRL_FILT] || want == pend) begin
                apply = want;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend <= DIR_HOLD;
        end else if (!rx_on_i || agc_ctrl[CTRL_OFF]) begin
            pend <= DIR_HOLD;
        end else if (strength_valid_i) begin
            pend <= (apply != DIR_HOLD) ? DIR_HOLD : want;
        end
    end

    // gain register; switch-on load and the ceiling take priority over stepping
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gain <= RST_GAIN_CEIL[LEVEL_MSB:0];
        end else if ((rx_on_i && !rx_prev) || agc_ctrl[CTRL_OFF]) begin
            gain <= ceiling;
        end else if (gain > ceiling) begin
            gain <= ceiling;
        end else if (rx_on_i) begin
            unique case (apply)
                DIR_UP:   gain <= gain + 5'h01;
                DIR_DOWN: gain <= gain - 5'h01;
                DIR_HOLD: gain <= gain;
                default:  gain <= gain;
            endcase
        end
    end

    assign vga_gain_o = gain;

    // edge history for switch-on and carrier sense events
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_prev <= 1'b0;
            cs_prev <= 1'b0;
        end else begin
            rx_prev <= rx_on_i;
            cs_prev <= carrier_sense;
        end
    end

    // lock detector

    assign lock_cfg.window_wide = lock_pin_reg[WIN_BIT];
    assign lock_cfg.up_down     = lock_pin_reg[MODE_BIT];
    assign lock_cfg.accuracy    = lock_pin_reg[1:0];

    agl_lock_det u_lock_det (
        .sys_clk_i    (sys_clk_i),
        .resetn_i     (resetn_i),
        .cfg_i        (lock_cfg),
        .cmp_valid_i  (cmp_valid_i),
        .cmp_offset_i (cmp_offset_i),
        .st_o         (lock_st)
    );

    // status pin

    assign pin_sel = lock_pin_reg[SEL_MSB:SEL_LSB];

    // status sources are active low on the pin; taps pass through one flop
    always_comb begin
        next_pin = 1'b0;
        unique case (pin_sel)
            SEL_LOW:  next_pin = 1'b0;
            SEL_HIGH: next_pin = 1'b1;
            SEL_CONT: next_pin = !lock_st.continuous_lock_flag;
            SEL_INST: next_pin = !lock_st.instant_lock_flag;
            SEL_CS:   next_pin = !carrier_sense;
            SEL_CAL:  next_pin = !cal_done_i;
            SEL_SEQ:  next_pin = !sequencing_error_flag_i;
            default:  next_pin = taps_i[4'(pin_sel - SEL_TAP0)];
        endcase
    end

    // registered so the pin never glitches while the selector changes
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_pin_o <= 1'b0;
        end else begin
            status_pin_o <= next_pin;
        end
    end

endmodule

/* tb/agl_host_model.sv */
// host side model that watches the status pin
`timescale 1ns/100ps
module agl_host_model (
    // clock
    input  wire logic sys_clk_i,
    // pin from the block
    input  wire logic status_pin_i,
    // level as the host reads it
    output logic      level_o
);
    // host sees the pin one cycle late
    always_ff @(posedge sys_clk_i) begin
        level_o <= status_pin_i;
    end
endmodule

/* tb/agl_top_asserts.sv */
// port checker for the gain control and lock detect block
`timescale 1ns/100ps
module agl_top_chk
    import agl_pkg::*;
(
    // clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               resetn_i,
    // register bus
    input  wire logic               hsel_i,
    input  wire logic [7:0]         haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    input  wire logic               hreadyout_o,
    input  wire logic               hresp_o,
    // receive chain and status pin
    input  wire logic               rx_on_i,
    input  wire logic               strength_valid_i,
    input  wire logic [6:0]         strength_i,
    input  wire logic [4:0]         vga_gain_o,
    input  wire logic               cal_done_i,
    input  wire logic [TAP_NUM-1:0] taps_i,
    input  wire logic               status_pin_o
);
    logic       ph_v;
    logic [7:0] ph_a, ceil_q, inc_q;
    logic [3:0] sel_q;
    logic [1:0] ctl_q;
    logic [8:0] tap_d;
    logic [6:0] up_lim, dn_lim;

    // configuration shadow, rebuilt from writes
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ph_v   <= 1'b0;
            ph_a   <= 8'h00;
            ceil_q <= RST_GAIN_CEIL;
            inc_q  <= RST_GAIN_INC;
            sel_q  <= 4'h0;
            ctl_q  <= RST_AGC_CTRL;
        end else begin
            ph_v <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
            ph_a <= haddr_i;
            if (ph_v && hready_i) begin
                case (ph_a)
                    {IDX_GAIN_CEIL, 2'b00}: ceil_q <= hwdata_i[7:0];
                    {IDX_GAIN_INC, 2'b00}:  inc_q <= hwdata_i[7:0];
                    {IDX_LOCK_PIN, 2'b00}:  sel_q <= hwdata_i[7:4];
                    {IDX_AGC_CTRL, 2'b00}:  ctl_q <= hwdata_i[1:0];
                    default: ;
                endcase
            end
        end
    end

    // taps one edge ago
    always_ff @(posedge sys_clk_i) begin
        tap_d <= taps_i;
    end

    // gain thresholds in strength steps
    assign up_lim = {2'h0, inc_q[4:0]} + THR_BASE + {4'h0, inc_q[7:5]};
    assign dn_lim = up_lim + THR_DOWN_MIN + {4'h0, ceil_q[7:5]};

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_bus_okay; hreadyout_o && !hresp_o; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
    property p_rx_load; $rose(rx_on_i) |-> ##[1:2] vga_gain_o == ceil_q[4:0]; endproperty
    a_rx_load: assert property (p_rx_load) else $error("gain not loaded at rx on");
    property p_ceiling; vga_gain_o > ceil_q[4:0] |=> vga_gain_o <= ceil_q[4:0]; endproperty
    a_ceiling: assert property (p_ceiling) else $error("gain above ceiling");
    property p_agc_off;
        ctl_q[0] && $past(ctl_q[0]) && $stable(ceil_q) |-> vga_gain_o == ceil_q[4:0];
    endproperty
    a_agc_off: assert property (p_agc_off) else $error("gain moved while control off");
    // steps judged with settled setup, filter off
    sequence s_step;
        strength_valid_i && rx_on_i && $past(rx_on_i) && ctl_q == 2'h0 && $stable(ceil_q)
            && $stable(inc_q) && vga_gain_o <= ceil_q[4:0];
    endsequence
    property p_step_up;
        s_step ##0 (strength_i < up_lim && vga_gain_o < ceil_q[4:0])
            |=> vga_gain_o == $past(vga_gain_o) + 5'h01;
    endproperty
    a_step_up: assert property (p_step_up) else $error("gain did not step up");
    property p_step_dn;
        s_step ##0 (strength_i > dn_lim && vga_gain_o != 5'h00)
            |=> vga_gain_o == $past(vga_gain_o) - 5'h01;
    endproperty
    a_step_dn: assert property (p_step_dn) else $error("gain did not step down");
    property p_pin_const; sel_q <= SEL_HIGH && $stable(sel_q) |-> status_pin_o == sel_q[0]; endproperty
    a_pin_const: assert property (p_pin_const) else $error("constant pin code wrong");
    property p_pin_cs;
        (sel_q == SEL_CS && $stable(strength_i) && $stable(inc_q))[*3]
            |-> status_pin_o == !(strength_i > {2'h0, inc_q[4:0]});
    endproperty
    a_pin_cs: assert property (p_pin_cs) else $error("carrier sense pin wrong");
    property p_pin_cal; (sel_q == SEL_CAL && $stable(cal_done_i))[*2] |-> status_pin_o == !cal_done_i; endproperty
    a_pin_cal: assert property (p_pin_cal) else $error("cal done pin wrong");
    property p_pin_tap; sel_q >= SEL_TAP0 && $stable(sel_q) |-> status_pin_o == tap_d[sel_q - SEL_TAP0]; endproperty
    a_pin_tap: assert property (p_pin_tap) else $error("tap pin wrong");

    c_down: cover property (strength_valid_i && strength_i > dn_lim);
    c_off:  cover property (ctl_q[0] && rx_on_i);
    c_tap:  cover property (sel_q == 4'hF);
endmodule

/* tb/tb_top.sv */
// testbench for the gain control and lock detect block
`timescale 1ns/100ps
module tb_top;
    import agl_pkg::*;
    logic        sys_clk_i = 1'b0, resetn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, rx_on_i = 1'b0;
    logic        strength_valid_i = 1'b0, cmp_valid_i = 1'b0, cal_done_i = 1'b0, sequencing_error_flag_i = 1'b0;
    logic        hreadyout_o, hresp_o, status_pin_o, irq_o, pin_lvl;
    logic [1:0]  htrans_i = 2'h0;
    logic [7:0]  haddr_i = 8'h00;
    logic [31:0] hwdata_i = 32'h0, hrdata_o, rd;
    logic [6:0]  strength_i = 7'h00;
    logic [2:0]  cmp_offset_i = 3'h0;
    logic [8:0]  taps_i = 9'h000;
    logic [4:0]  vga_gain_o;
    int          errors = 0, total_checks = 0, cycles = 0;

    agl_top dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .rx_on_i(rx_on_i), .strength_valid_i(strength_valid_i), .strength_i(strength_i),
        .vga_gain_o(vga_gain_o), .cmp_valid_i(cmp_valid_i), .cmp_offset_i(cmp_offset_i),
        .cal_done_i(cal_done_i), .sequencing_error_flag_i(sequencing_error_flag_i), .taps_i(taps_i),
        .status_pin_o(status_pin_o), .irq_o(irq_o));
    agl_host_model host (.sys_clk_i(sys_clk_i), .status_pin_i(status_pin_o), .level_o(pin_lvl));

    // clock, moving taps, run ceiling
    always #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        taps_i <= taps_i + 9'h001;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus transfer; read data taken at the data phase end
    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge sys_clk_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= {idx, 2'b00};
        hwrite_i <= w;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    // one strength sample, then check gain
    task automatic smp(input logic [6:0] s, input logic [4:0] exp);
        @(posedge sys_clk_i);
        strength_i       <= s;
        strength_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        strength_valid_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk({27'h0, vga_gain_o}, {27'h0, exp});
    endtask
    // n comparisons, then read instant and continuous lock
    task automatic cmp(input int n, input logic [2:0] off, input logic [1:0] exp);
        repeat (n) begin
            @(posedge sys_clk_i);
            cmp_valid_i  <= 1'b1;
            cmp_offset_i <= off;
        end
        @(posedge sys_clk_i);
        cmp_valid_i <= 1'b0;
        bus(1'b0, IDX_LIVE_STATUS, 32'h0);
        chk({30'h0, rd[9:8]}, {30'h0, exp});
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        chk({27'h0, vga_gain_o}, 32'h18);
        rdc(IDX_GAIN_CEIL, 32'h38);
        rdc(IDX_GAIN_INC, 32'h38);
        rdc(IDX_LOCK_PIN, 32'h0);
        rdc(IDX_AGC_CTRL, 32'h2);
        rdc(6'h1C, 32'h0);
        $display("test registers done");
        bus(1'b1, IDX_AGC_CTRL, 32'h0);
        rx_on_i <= 1'b1;
        smp(7'h00, 5'h18);
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, IDX_GAIN_CEIL, {24'h0, k[2:0], 5'h18});
            bus(1'b1, IDX_GAIN_INC, {24'h0, k[2:0], 5'h18});
            smp(7'h24 + 7'(2 * k), 5'h17);
            smp(7'h23 + 7'(2 * k), 5'h17);
            smp(7'h20 + 7'(k), 5'h17);
            smp(7'h1F + 7'(k), 5'h18);
        end
        bus(1'b1, IDX_AGC_CTRL, 32'h2);
        smp(7'h40, 5'h18);
        smp(7'h40, 5'h17);
        bus(1'b1, IDX_AGC_CTRL, 32'h1);
        smp(7'h40, 5'h18);
        bus(1'b1, IDX_GAIN_CEIL, 32'hF4);
        smp(7'h00, 5'h14);
        bus(1'b1, IDX_AGC_CTRL, 32'h0);
        smp(7'h00, 5'h14);
        smp(7'h40, 5'h13);
        rx_on_i <= 1'b0;
        @(posedge sys_clk_i);
        rx_on_i <= 1'b1;
        smp(7'h2C, 5'h14);
        $display("test gain done");
        cal_done_i  <= 1'b1;
        sequencing_error_flag_i <= 1'b1;
        for (int s = 0; s < 16; s++) begin
            bus(1'b1, IDX_LOCK_PIN, {24'h0, s[3:0], 4'h0});
            repeat (3) @(posedge sys_clk_i);
            if (s < 7) chk({31'h0, pin_lvl}, 32'((7'h0E >> s) & 7'h01));
        end
        bus(1'b1, IDX_LOCK_PIN, 32'h40);
        strength_i <= 7'h18;
        repeat (3) @(posedge sys_clk_i);
        chk({31'h0, pin_lvl}, 32'h1);
        $display("test pin done");
        bus(1'b1, IDX_LOCK_PIN, 32'h20);
        bus(1'b1, IDX_IRQ_MASK, 32'h3);
        bus(1'b1, IDX_IRQ_STATUS, 32'h7);
        cmp(126, 3'h1, 2'b10);
        cmp(1, 3'h1, 2'b11);
        chk({30'h0, pin_lvl, irq_o}, 32'h1);
        cmp(1, 3'h2, 2'b00);
        rdc(IDX_IRQ_STATUS, 32'h3);
        bus(1'b1, IDX_IRQ_STATUS, 32'h3);
        rdc(IDX_IRQ_STATUS, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, IDX_LOCK_PIN, 32'h2C);
        cmp(126, 3'h3, 2'b10);
        cmp(1, 3'h3, 2'b11);
        cmp(15, 3'h4, 2'b01);
        cmp(1, 3'h4, 2'b00);
        bus(1'b1, IDX_IRQ_MASK, 32'h0);
        for (int a = 1; a < 4; a++) begin
            bus(1'b1, IDX_LOCK_PIN, 32'h20 | a);
            cmp(1, 3'h2, 2'b00);
            cmp((128 << a) - 2, 3'h0, 2'b10);
            cmp(1, 3'h0, 2'b11);
            chk({31'h0, irq_o}, 32'h0);
        end
        bus(1'b1, IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge sys_clk_i);
        chk({31'h0, irq_o}, 32'h1);
        $display("test lock done");
        wrap_up();
    end
endmodule

bind agl_top agl_top_chk u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rx_on_i(rx_on_i),
    .strength_valid_i(strength_valid_i), .strength_i(strength_i), .vga_gain_o(vga_gain_o),
    .cal_done_i(cal_done_i), .taps_i(taps_i), .status_pin_o(status_pin_o));
